//--- core/ccdp_loader.sv
// Overview of operation
// - passive schemes: clock pin is input, data sampled on its rising edges
// - self serial scheme: device drives clock pin timing flash transfers
// - self parallel scheme: device drives clock pin timing the interface
// - self schemes after loading: clock driven inactive or released to user
// - passive schemes: clock pin never becomes a user pin
// - clock toggling after loading leaves loaded state unchanged
// - serial schemes: one bit per clock on lowest data line, as input
// - after self serial loading lowest data line stays dedicated input
// - after passive loading lowest data line follows dual-use setting
// - after self parallel loading lowest line is bidirectional, user controlled
// - self serial scheme: second line drives flash read command stream
// - other schemes using it: second line is a data input
// - after self serial loading second line stays dedicated output
// - slave serial scheme: second line tri-stated during loading
// - after slave parallel loading second line follows dual-use setting
// - self parallel scheme: data moves byte-wide or word-wide
// - after self parallel loading second line bidirectional, user controlled
`timescale 1ns/1ps
module ccdp_loader (
  input  wire logic                  sys_clk_in,             // 25 MHz clock
  input  wire logic                  sys_rst_in,             // async reset, high
  input  wire ccdp_pkg::ccdp_mode_t  mode_in,                // scheme, taken at start
  input  wire logic                  word_wide_in,           // 16-bit self parallel
  input  wire logic                  load_start_in,          // begin loading
  input  wire logic                  load_done_in,           // loading complete
  input  wire logic                  user_io_en_in,          // optional user control
  input  wire logic                  dual_use_user_in,       // dual-use pins to user
  input  wire ccdp_pkg::ccdp_pad_t   clk_user_in,            // user drive, clock pin
  input  wire ccdp_pkg::ccdp_pad_t   d0_user_in,             // user drive, line 0
  input  wire ccdp_pkg::ccdp_pad_t   d1_user_in,             // user drive, line 1
  input  wire logic                  config_clock_pin_in,    // clock pin level
  output logic                       config_clock_pin_out,   // clock pin drive
  output logic                       config_clock_pin_oe_out,// clock pin enable
  input  wire logic [15:0]           data_pin_in,            // data pin levels
  output logic                       data0_out,              // line 0 drive
  output logic                       data0_oe_out,           // line 0 enable
  output logic                       flash_command_out,      // line 1 drive
  output logic                       flash_command_oe_out,   // line 1 enable
  output logic                       d0_user_rd_out,         // line 0 to user
  output logic                       d1_user_rd_out,         // line 1 to user
  output logic [15:0]                cfg_word_out,           // loaded data word
  output logic                       cfg_valid_out,          // word available
  input  wire logic                  cfg_ready_in,           // consumer takes word
  output logic                       overflow_out,           // passive data lost
  output logic                       busy_out                // loading in progress
);

  typedef struct packed {
    ccdp_pkg::ccdp_state_t state;
    ccdp_pkg::ccdp_mode_t  mode;
    logic                  word;
    logic [2:0]            clk_s;
    logic                  clk_lvl;
    logic [15:0]           d_s1;
    logic [15:0]           d_s2;
    logic [15:0]           d_s3;
    logic [ccdp_pkg::DIV_W-1:0] div;
    logic                  clk_drv;
    logic [31:0]           cmd;
    logic [4:0]            cmd_cnt;
    logic                  d1_cmd;
    logic [7:0]            shift;
    logic [2:0]            bit_cnt;
    logic                  push_v;
    logic [15:0]           push_data;
    logic                  overflow;
    logic                  clk_o;
    logic                  clk_oe;
    logic                  d0_o;
    logic                  d0_oe;
    logic                  d1_o;
    logic                  d1_oe;
    logic                  d0_rd;
    logic                  d1_rd;
  } ccdp_st_t;

  ccdp_st_t r;
  ccdp_st_t next_r;
  logic     fifo_in_ready;
  logic     self_m;
  logic     serial_m;
  logic     cfg;
  logic     ext_rise;
  logic     self_rise;
  logic     n_self;
  logic     n_cfg;
  logic     n_usr;

  // scheme decode on the captured mode
  assign self_m   = (r.mode == ccdp_pkg::self_driven_serial_mode) ||
                    (r.mode == ccdp_pkg::self_driven_parallel_mode);
  assign serial_m = (r.mode == ccdp_pkg::self_driven_serial_mode) ||
                    (r.mode == ccdp_pkg::slave_serial_mode);
  assign cfg      = (r.state == ccdp_pkg::ST_CMD) || (r.state == ccdp_pkg::ST_XFER);

  // external edge once stages two and three agree on a new high
  assign ext_rise  = !self_m && (r.clk_s[1] == r.clk_s[2]) && r.clk_s[2] && !r.clk_lvl;
  // own clock rises only with room downstream
  assign self_rise = self_m && cfg && !load_done_in && (r.div == ccdp_pkg::DIV_END) &&
                     !r.clk_drv && fifo_in_ready && !r.push_v;

  // next-state logic
  always_comb begin
    next_r        = r;
    next_r.push_v = 1'b0;
    n_self        = 1'b0;
    n_cfg         = 1'b0;
    n_usr         = 1'b0;
    // pin synchronisers
    next_r.clk_s = {r.clk_s[1:0], config_clock_pin_in};
    next_r.d_s1  = data_pin_in;
    next_r.d_s2  = r.d_s1;
    next_r.d_s3  = r.d_s2;
    if (r.clk_s[1] == r.clk_s[2]) begin
      next_r.clk_lvl = r.clk_s[2];
    end
    case (r.state)
      ccdp_pkg::ST_IDLE: begin
        if (load_start_in) begin
          next_r.mode    = mode_in;
          next_r.word    = word_wide_in;
          next_r.div     = '0;
          next_r.clk_drv = 1'b0;
          next_r.bit_cnt = '0;
          next_r.cmd_cnt = '0;
          next_r.d1_cmd  = ccdp_pkg::CMD_WORD[31];
          next_r.cmd     = {ccdp_pkg::CMD_WORD[30:0], 1'b0};
          if (mode_in == ccdp_pkg::self_driven_serial_mode) begin
            next_r.state = ccdp_pkg::ST_CMD;
          end else begin
            next_r.state = ccdp_pkg::ST_XFER;
          end
        end
      end
      ccdp_pkg::ST_CMD, ccdp_pkg::ST_XFER: begin
        if (load_done_in) begin
          next_r.state = ccdp_pkg::ST_USER;
        end else begin
          // divider for the driven clock, held low on stall
          if (self_m) begin
            if (r.div != ccdp_pkg::DIV_END) begin
              next_r.div = r.div + 1'b1;
            end else if (r.clk_drv) begin
              next_r.div     = '0;
              next_r.clk_drv = 1'b0;
              if (r.state == ccdp_pkg::ST_CMD) begin
                next_r.d1_cmd = r.cmd[31];
                next_r.cmd    = {r.cmd[30:0], 1'b0};
              end
            end else if (self_rise) begin
              next_r.div     = '0;
              next_r.clk_drv = 1'b1;
            end
          end
          // command phase counts bits taken by the flash
          if (self_rise && (r.state == ccdp_pkg::ST_CMD)) begin
            next_r.cmd_cnt = r.cmd_cnt + 1'b1;
            if (r.cmd_cnt == ccdp_pkg::CMD_LAST) begin
              next_r.state = ccdp_pkg::ST_XFER;
            end
          end else if ((self_rise || ext_rise) && (r.state == ccdp_pkg::ST_XFER)) begin
            // capture on the rising edge
            if (serial_m) begin
              next_r.shift   = {r.d_s3[0], r.shift[7:1]};
              next_r.bit_cnt = r.bit_cnt + 1'b1;
              if (r.bit_cnt == ccdp_pkg::BIT_LAST) begin
                next_r.push_v    = 1'b1;
                next_r.push_data = {ccdp_pkg::PAD_BYTE, r.d_s3[0], r.shift[7:1]};
              end
            end else begin
              next_r.push_v = 1'b1;
              if (self_m && r.word) begin
                next_r.push_data = r.d_s3;
              end else begin
                next_r.push_data = {ccdp_pkg::PAD_BYTE, r.d_s3[7:0]};
              end
            end
          end
        end
      end
      ccdp_pkg::ST_USER: begin
        next_r.state = ccdp_pkg::ST_USER;
      end
      default: begin
        next_r.state = ccdp_pkg::ST_IDLE;
      end
    endcase
    // sticky loss flag, passive host cannot be stalled
    if (r.push_v && !fifo_in_ready) begin
      next_r.overflow = 1'b1;
    end
    // pin roles follow the next state
    n_self = (next_r.mode == ccdp_pkg::self_driven_serial_mode) ||
             (next_r.mode == ccdp_pkg::self_driven_parallel_mode);
    n_cfg  = (next_r.state == ccdp_pkg::ST_CMD) || (next_r.state == ccdp_pkg::ST_XFER);
    n_usr  = next_r.state == ccdp_pkg::ST_USER;
    next_r.clk_o  = 1'b0;
    next_r.clk_oe = 1'b0;
    next_r.d0_o   = 1'b0;
    next_r.d0_oe  = 1'b0;
    next_r.d1_o   = 1'b0;
    next_r.d1_oe  = 1'b0;
    // clock pin
    if (n_self && n_cfg) begin
      next_r.clk_o  = next_r.clk_drv;
      next_r.clk_oe = 1'b1;
    end else if (n_self && n_usr) begin
      if (user_io_en_in) begin
        next_r.clk_o  = clk_user_in.out;
        next_r.clk_oe = clk_user_in.oe;
      end else begin
        next_r.clk_oe = 1'b1;
      end
    end
    // data lines after loading, and line 1 during self serial loading
    if (n_usr) begin
      case (next_r.mode)
        ccdp_pkg::slave_serial_mode, ccdp_pkg::slave_parallel_mode: begin
          if (dual_use_user_in) begin
            next_r.d0_o  = d0_user_in.out;
            next_r.d0_oe = d0_user_in.oe;
            next_r.d1_o  = d1_user_in.out;
            next_r.d1_oe = d1_user_in.oe;
          end
        end
        ccdp_pkg::self_driven_serial_mode: begin
          next_r.d1_oe = 1'b1;
          next_r.d1_o  = user_io_en_in ? d1_user_in.out : 1'b1;
        end
        ccdp_pkg::self_driven_parallel_mode: begin
          if (user_io_en_in) begin
            next_r.d0_o  = d0_user_in.out;
            next_r.d0_oe = d0_user_in.oe;
            next_r.d1_o  = d1_user_in.out;
            next_r.d1_oe = d1_user_in.oe;
          end
        end
        default: begin
          next_r.d0_oe = 1'b0;
        end
      endcase
    end else if (n_cfg && (next_r.mode == ccdp_pkg::self_driven_serial_mode)) begin
      next_r.d1_o  = next_r.d1_cmd;
      next_r.d1_oe = 1'b1;
    end
    // line levels handed to user logic
    next_r.d0_rd = n_usr && r.d_s3[0];
    next_r.d1_rd = n_usr && r.d_s3[1];
  end

  // state register
  always_ff @(posedge sys_clk_in or posedge sys_rst_in) begin
    if (sys_rst_in) begin
      r <= '0;
    end else begin
      r <= next_r;
    end
  end

  // loaded words buffered toward the consumer
  ccdp_fifo #(
    .WIDTH (ccdp_pkg::WORD_W),
    .DEPTH (ccdp_pkg::FIFO_DEPTH)
  ) u_fifo (
    .sys_clk_in    (sys_clk_in),
    .sys_rst_in    (sys_rst_in),
    .in_valid_in   (r.push_v),
    .in_ready_out  (fifo_in_ready),
    .in_data_in    (r.push_data),
    .out_valid_out (cfg_valid_out),
    .out_ready_in  (cfg_ready_in),
    .out_data_out  (cfg_word_out)
  );

  // outputs from the state register
  assign config_clock_pin_out    = r.clk_o;
  assign config_clock_pin_oe_out = r.clk_oe;
  assign data0_out               = r.d0_o;
  assign data0_oe_out            = r.d0_oe;
  assign flash_command_out       = r.d1_o;
  assign flash_command_oe_out    = r.d1_oe;
  assign d0_user_rd_out          = r.d0_rd;
  assign d1_user_rd_out          = r.d1_rd;
  assign overflow_out            = r.overflow;
  assign busy_out                = cfg;

  // checks
  default clocking cb @(posedge sys_clk_in);
  endclocking
  default disable iff (sys_rst_in);

  sequence s_serial_edge;
    !self_m && serial_m && (r.state == ccdp_pkg::ST_XFER) && !load_done_in && ext_rise;
  endsequence
  sequence s_word_edge;
    (r.mode == ccdp_pkg::self_driven_parallel_mode) && r.word &&
    (r.state == ccdp_pkg::ST_XFER) && self_rise;
  endsequence
  sequence s_cmd_fall;
    (r.state == ccdp_pkg::ST_CMD) && $fell(config_clock_pin_out);
  endsequence

  property p_passive_in;
    !self_m |-> !config_clock_pin_oe_out;
  endproperty
  a_passive_in: assert property (p_passive_in)
    else $error("clock pin driven in passive scheme");

  property p_serial_bit;
    s_serial_edge |=> r.bit_cnt == $past(r.bit_cnt) + 3'h1;
  endproperty
  a_serial_bit: assert property (p_serial_bit)
    else $error("passive edge did not take a bit");

  property p_cmd_drive;
    (r.state == ccdp_pkg::ST_CMD) |-> config_clock_pin_oe_out && flash_command_oe_out;
  endproperty
  a_cmd_drive: assert property (p_cmd_drive)
    else $error("self serial pins not driven");

  property p_clk_high;
    self_m && cfg && $rose(config_clock_pin_out) |->
      (config_clock_pin_out || (r.state == ccdp_pkg::ST_USER))[*4];
  endproperty
  a_clk_high: assert property (p_clk_high)
    else $error("driven clock high phase too short");

  property p_inactive;
    self_m && ($past(r.state) == ccdp_pkg::ST_USER) && !$past(user_io_en_in) |->
      config_clock_pin_oe_out && !config_clock_pin_out;
  endproperty
  a_inactive: assert property (p_inactive)
    else $error("clock not inactive after loading");

  property p_user_quiet;
    (r.state == ccdp_pkg::ST_USER) |=> !r.push_v [*2];
  endproperty
  a_user_quiet: assert property (p_user_quiet)
    else $error("data taken after loading");

  property p_cmd_bit;
    s_cmd_fall |-> flash_command_out == $past(r.cmd[31]);
  endproperty
  a_cmd_bit: assert property (p_cmd_bit)
    else $error("command bit wrong on falling edge");

  property p_ps_tristate;
    (r.mode == ccdp_pkg::slave_serial_mode) && cfg |-> !flash_command_oe_out;
  endproperty
  a_ps_tristate: assert property (p_ps_tristate)
    else $error("line 1 driven in slave serial loading");

  property p_par_input;
    !serial_m && cfg |-> !flash_command_oe_out && !data0_oe_out;
  endproperty
  a_par_input: assert property (p_par_input)
    else $error("line 1 driven in parallel loading");

  property p_word;
    s_word_edge |=> r.push_v && (r.push_data == $past(r.d_s3));
  endproperty
  a_word: assert property (p_word)
    else $error("word-wide capture wrong");

  property p_as_d0_in;
    (r.mode == ccdp_pkg::self_driven_serial_mode) |-> !data0_oe_out;
  endproperty
  a_as_d0_in: assert property (p_as_d0_in)
    else $error("line 0 driven in self serial scheme");

endmodule : ccdp_loader

//--- core/ccdp_pkg.sv
package ccdp_pkg;

  // configuration schemes
  typedef enum logic [1:0] {
    slave_serial_mode         = 2'h0,
    slave_parallel_mode       = 2'h1,
    self_driven_serial_mode   = 2'h2,
    self_driven_parallel_mode = 2'h3
  } ccdp_mode_t;

  // loader phases
  typedef enum logic [1:0] {
    ST_IDLE = 2'h0,
    ST_CMD  = 2'h1,
    ST_XFER = 2'h2,
    ST_USER = 2'h3
  } ccdp_state_t;

  // user drive request for one pin
  typedef struct packed {
    logic out;
    logic oe;
  } ccdp_pad_t;

  // timing of the self-driven clock
  localparam int SYS_CLK_MHZ  = 25;
  localparam int CLK_HALF_NS  = 160;
  localparam int CLK_HALF_CYC = (CLK_HALF_NS * SYS_CLK_MHZ + 999) / 1000;
  localparam int DIV_W        = 3;
  localparam logic [DIV_W-1:0] DIV_END = DIV_W'(CLK_HALF_CYC - 1);

  // flash read command: opcode then start address
  localparam logic [7:0]  READ_OP    = 8'h03;
  localparam logic [23:0] START_ADDR = 24'h00_0000;
  localparam logic [31:0] CMD_WORD   = {READ_OP, START_ADDR};
  localparam logic [4:0]  CMD_LAST   = 5'h1f;

  // data path
  localparam int          WORD_W     = 16;
  localparam int          FIFO_DEPTH = 4;
  localparam logic [2:0]  BIT_LAST   = 3'h7;
  localparam logic [7:0]  PAD_BYTE   = 8'h00;

endpackage : ccdp_pkg

//--- core/ccdp_fifo.sv
`timescale 1ns/1ps
module ccdp_fifo #(
  parameter int WIDTH = 16,
  parameter int DEPTH = 4
) (
  input  wire logic             sys_clk_in,   // system clock
  input  wire logic             sys_rst_in,   // async reset, high
  input  wire logic             in_valid_in,  // write request
  output logic                  in_ready_out, // room for a word
  input  wire logic [WIDTH-1:0] in_data_in,   // write data
  output logic                  out_valid_out,// word available
  input  wire logic             out_ready_in, // reader takes word
  output logic [WIDTH-1:0]      out_data_out  // head word
);
  localparam int AW = $clog2(DEPTH);

  typedef struct packed {
    logic [DEPTH-1:0][WIDTH-1:0] mem;
    logic [AW-1:0]               wp;
    logic [AW-1:0]               rp;
    logic [AW:0]                 cnt;
  } ccdp_fifo_st_t;

  ccdp_fifo_st_t r;
  ccdp_fifo_st_t next_r;
  logic          wr;
  logic          rd;

  // honest flags from the fill count
  assign in_ready_out  = r.cnt != (AW+1)'(DEPTH);
  assign out_valid_out = r.cnt != '0;
  assign out_data_out  = r.mem[r.rp];
  assign wr = in_valid_in && in_ready_out;
  assign rd = out_valid_out && out_ready_in;

  // pointer and count update
  always_comb begin
    next_r = r;
    for (int i = 0; i < DEPTH; i++) begin
      if (wr && (r.wp == AW'(i))) begin
        next_r.mem[i] = in_data_in;
      end
    end
    if (wr) begin
      next_r.wp = r.wp + 1'b1;
    end
    if (rd) begin
      next_r.rp = r.rp + 1'b1;
    end
    if (wr && !rd) begin
      next_r.cnt = r.cnt + 1'b1;
    end else if (rd && !wr) begin
      next_r.cnt = r.cnt - 1'b1;
    end
  end

  // state register
  always_ff @(posedge sys_clk_in or posedge sys_rst_in) begin
    if (sys_rst_in) begin
      r <= '0;
    end else begin
      r <= next_r;
    end
  end

endmodule : ccdp_fifo

//--- tb/ccdp_far_model.sv
`timescale 1ns/1ps
module ccdp_far_model (
  input  wire ccdp_pkg::ccdp_mode_t mode_in,       // scheme in use
  input  wire logic                 dev_clk_in,    // device clock drive
  input  wire logic                 dev_clk_oe_in, // device clock enable
  input  wire logic                 d0_in,         // device line 0 drive
  input  wire logic                 d0_oe_in,      // device line 0 enable
  input  wire logic                 cmd_in,        // device line 1 drive
  input  wire logic                 cmd_oe_in,     // device line 1 enable
  output logic                      clk_pin_out,   // resolved clock pin
  output logic [15:0]               data_pin_out   // resolved data pins
);
  logic        host_clk;
  logic [15:0] host_data;
  logic [15:0] flash_data;
  logic [15:0] base;
  logic [31:0] cmd_sr;
  int          cmd_cnt;
  int          idx;
  int          bit_n;

  // byte pattern held by host and flash
  function automatic logic [7:0] pat(input int i);
    return 8'h5a ^ 8'(i * 32'h0000_0027);
  endfunction : pat

  function automatic logic [15:0] word(input int i);
    return {~pat(i), pat(i)};
  endfunction : word

  // pins: driving party wins, released lines show host or flash data
  assign base         = mode_in[1] ? flash_data : host_data;
  assign clk_pin_out  = dev_clk_oe_in ? dev_clk_in : host_clk;
  assign data_pin_out = {base[15:2], cmd_oe_in ? cmd_in : base[1], d0_oe_in ? d0_in : base[0]};

  task arm;
    host_clk   = 1'b0;
    host_data  = 16'h0000;
    flash_data = (mode_in == ccdp_pkg::self_driven_parallel_mode) ? word(0) : 16'h0000;
    cmd_cnt    = 0;
    idx        = 0;
    bit_n      = 0;
  endtask : arm

  // host: data set at the fall, held a half period either side of the rise
  task pulse(input logic [15:0] d);
    host_data = d;
    #160 host_clk = 1'b1;
    #160 host_clk = 1'b0;
  endtask : pulse

  task send(input int n, input logic serial);
    logic [7:0] v;
    for (int i = 0; i < n; i++) begin
      v = pat(i);
      if (serial) begin
        for (int b = 0; b < 8; b++) pulse({~host_data[15:1], v[b]});
      end else begin
        pulse({~host_data[15:8], v});
      end
    end
    host_data = ~host_data;
  endtask : send

  // flash: collect command bits on rising edges
  always @(posedge clk_pin_out) begin
    if (mode_in == ccdp_pkg::self_driven_serial_mode && cmd_cnt < 32) begin
      cmd_sr = {cmd_sr[30:0], data_pin_out[1]};
      cmd_cnt++;
    end
  end

  // flash: next data on falling edges
  always @(negedge clk_pin_out) begin
    logic [7:0] v;
    if (mode_in == ccdp_pkg::self_driven_parallel_mode) begin
      idx++;
      flash_data = word(idx);
    end else if (mode_in == ccdp_pkg::self_driven_serial_mode && cmd_cnt == 32) begin
      v          = pat(idx);
      flash_data = {~flash_data[15:1], v[bit_n]};
      if (bit_n == 7) begin
        bit_n = 0;
        idx++;
      end else begin
        bit_n++;
      end
    end
  end
endmodule : ccdp_far_model

//--- tb/testbench.sv
`timescale 1ns/1ps
module testbench;
  logic                 sys_clk;
  logic                 sys_rst;
  ccdp_pkg::ccdp_mode_t mode;
  logic                 word_wide, load_start, load_done, user_io_en, dual_use, cfg_ready;
  ccdp_pkg::ccdp_pad_t  clk_user, d0_user, d1_user;
  wire logic            clk_pin;
  wire logic [15:0]     data_pin;
  logic                 clk_out, clk_oe, d0_out, d0_oe, cmd_out, cmd_oe;
  logic                 cfg_valid, overflow, busy, d0_rd, d1_rd;
  logic [15:0]          cfg_word;
  int                   n_fail, comparisons, clk_rises;

  ccdp_loader dut (.sys_clk_in(sys_clk), .sys_rst_in(sys_rst), .mode_in(mode),
    .word_wide_in(word_wide), .load_start_in(load_start), .load_done_in(load_done),
    .user_io_en_in(user_io_en), .dual_use_user_in(dual_use), .clk_user_in(clk_user),
    .d0_user_in(d0_user), .d1_user_in(d1_user), .config_clock_pin_in(clk_pin),
    .config_clock_pin_out(clk_out), .config_clock_pin_oe_out(clk_oe), .data_pin_in(data_pin),
    .data0_out(d0_out), .data0_oe_out(d0_oe), .flash_command_out(cmd_out),
    .flash_command_oe_out(cmd_oe), .d0_user_rd_out(d0_rd), .d1_user_rd_out(d1_rd),
    .cfg_word_out(cfg_word), .cfg_valid_out(cfg_valid), .cfg_ready_in(cfg_ready),
    .overflow_out(overflow), .busy_out(busy));

  ccdp_far_model far (.mode_in(mode), .dev_clk_in(clk_out), .dev_clk_oe_in(clk_oe),
    .d0_in(d0_out), .d0_oe_in(d0_oe), .cmd_in(cmd_out), .cmd_oe_in(cmd_oe),
    .clk_pin_out(clk_pin), .data_pin_out(data_pin));

  // system clock and device clock edge count
  initial begin
    sys_clk = 1'b0;
    forever #20 sys_clk = ~sys_clk;
  end
  always @(posedge clk_out) clk_rises++;

  task step(input int n);
    repeat (n) @(posedge sys_clk);
    #1;
  endtask : step

  task check(input string what, input logic [31:0] seen, input logic [31:0] exp);
    comparisons++;
    if (seen !== exp) begin
      n_fail++;
      $display("MISMATCH %s expected %h seen %h", what, exp, seen);
    end
  endtask : check

  task final_report;
    if (n_fail == 0 && comparisons > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask : final_report

  // reset in the given scheme, then start loading
  task begin_load(input ccdp_pkg::ccdp_mode_t m, input logic w);
    mode = m; word_wide = w; load_done = 0; user_io_en = 0; dual_use = 0; cfg_ready = 0;
    clk_user = '0; d0_user = '0; d1_user = '0; load_start = 0; sys_rst = 1;
    step(16);
    far.arm(); // after the reset has parked the clock pin
    sys_rst = 0;
    step(1);
    check("busy after reset", busy, 0);
    check("clock enable after reset", clk_oe, 0);
    load_start = 1;
    step(1);
    load_start = 0;
    step(2);
  endtask : begin_load

  // wait for a word, compare it, take it
  task take(input logic [15:0] exp);
    int k;
    k = 0;
    while (cfg_valid !== 1'b1 && k < 3000) begin
      step(1);
      k++;
    end
    check("word valid", cfg_valid, 1);
    check("word", cfg_word, exp);
    cfg_ready = 1;
    step(1);
    cfg_ready = 0;
    step(1);
  endtask : take

  task t_slave_serial;
    begin_load(ccdp_pkg::slave_serial_mode, 1'b0);
    check("clock enable", clk_oe, 0);
    far.send(2, 1'b1);
    check("line1 enable", cmd_oe, 0);
    take({ccdp_pkg::PAD_BYTE, far.pat(0)});
    take({ccdp_pkg::PAD_BYTE, far.pat(1)});
    load_done = 1; user_io_en = 1; dual_use = 1; clk_user = 2'h3; d0_user = 2'h3;
    step(3);
    check("clock enable in user mode", clk_oe, 0);
    check("line0 enable", d0_oe, 1);
    check("line0 drive", d0_out, 1);
    dual_use = 0;
    step(3);
    check("line0 enable tristate", d0_oe, 0);
    far.send(1, 1'b1);
    step(8);
    check("word after load", cfg_valid, 0);
    check("busy after load", busy, 0);
  endtask : t_slave_serial

  // five bytes into four places: last one lost, then drain
  task t_slave_parallel;
    begin_load(ccdp_pkg::slave_parallel_mode, 1'b0);
    far.send(5, 1'b0);
    step(8);
    check("overflow", overflow, 1);
    for (int i = 0; i < 4; i++) take({ccdp_pkg::PAD_BYTE, far.pat(i)});
    step(2);
    check("drained", cfg_valid, 0);
    load_done = 1; dual_use = 1; d1_user = 2'h1;
    step(3);
    check("line1 enable", cmd_oe, 1);
    check("line1 drive", cmd_out, 0);
  endtask : t_slave_parallel

  task t_self_serial;
    int r;
    begin_load(ccdp_pkg::self_driven_serial_mode, 1'b0);
    check("clock enable", clk_oe, 1);
    check("line1 enable", cmd_oe, 1);
    check("first command bit", cmd_out, ccdp_pkg::CMD_WORD[31]);
    check("line0 enable", d0_oe, 0);
    step(900);
    r = clk_rises;
    step(64);
    check("clock rises while full", clk_rises - r, 0);
    check("flash command", far.cmd_sr, ccdp_pkg::CMD_WORD);
    for (int i = 0; i < 6; i++) take({ccdp_pkg::PAD_BYTE, far.pat(i)});
    load_done = 1;
    step(4);
    r = clk_rises;
    step(40);
    check("clock rises after load", clk_rises - r, 0);
    check("clock enable after load", clk_oe, 1);
    check("line1 enable after load", cmd_oe, 1);
    check("line1 idle drive", cmd_out, 1);
    check("line0 enable after load", d0_oe, 0);
    user_io_en = 1; d1_user = 2'h1; clk_user = 2'h3;
    step(3);
    check("line1 user drive", cmd_out, 0);
    check("clock user drive", clk_out, 1);
  endtask : t_self_serial

  task t_self_parallel(input logic w);
    begin_load(ccdp_pkg::self_driven_parallel_mode, w);
    check("clock enable", clk_oe, 1);
    check("line1 enable", cmd_oe, 0);
    for (int i = 0; i < 5; i++) take(w ? far.word(i) : {ccdp_pkg::PAD_BYTE, far.pat(i)});
    load_done = 1; user_io_en = 1; d0_user = 2'h3; d1_user = 2'h3;
    step(3);
    check("line0 enable", d0_oe, 1);
    check("line0 drive", d0_out, 1);
    check("line1 enable", cmd_oe, 1);
    check("line1 drive", cmd_out, 1);
    step(3);
    check("line0 to user", d0_rd, 1);
    check("line1 to user", d1_rd, 1);
  endtask : t_self_parallel

  // watchdog
  initial begin
    repeat (40000) @(posedge sys_clk);
    n_fail++;
    final_report();
  end

  // main sequence
  initial begin
    n_fail = 0; comparisons = 0; clk_rises = 0;
    t_slave_serial();
    t_slave_parallel();
    t_self_serial();
    t_self_parallel(1'b0);
    t_self_parallel(1'b1);
    final_report();
  end
endmodule : testbench
